// file: rtl/completion_interrupt_coalescer.sv
// Purpose: Per-vector completion interrupt coalescing with AHB-Lite regs
// Assumes: Single AHB-Lite slave, word transfers, synchronous inputs
// Notes:   Vector 0 serves the administrative completion queue
//
// Summary of operation
// - Interrupt when count threshold or hold-off time is met, first wins
// - Time or threshold of zero turns coalescing off
// - Admin completion queue vector is never coalesced
// - Completions reporting an error are signalled at once
// - Head doorbell write restarts that vector's count and timer
// - Time and threshold arrive in the settings word
// - Settings readback uses the same layout as written
// - Settings valid in every mode, cleared when mode changes
// - Bits 15:8 hold-off in 100 us steps, zero no delay, resets zero
// - Time limit may be per vector or shared; one limit shared by all vectors
// - Bits 7:0 zero-based entry threshold shared by all vectors, resets zero
// - After reset every vector bypasses coalescing, as time and threshold reset to zero
// - Bad or unbound vector in per-vector config flags invalid field
// - Bit 16 set exempts the vector from coalescing
// - Bits 15:0 select the vector being configured or queried
// - Per-vector query returns the selected vector's settings
`timescale 1ns/1ps
`default_nettype none
`include "coalesce_defs.svh"

module completion_interrupt_coalescer
	import coalesce_pkg::*;
#(
	parameter int NUM_VECTORS = 8,
	parameter int VW          = (NUM_VECTORS > 1) ? $clog2(NUM_VECTORS) : 1
)(
	// Clock and reset
	input  wire logic                   hclk,
	input  wire logic                   hresetn,
	// AHB-Lite slave
	input  wire logic                   hsel,
	input  wire logic [31:0]            haddr,
	input  wire logic [1:0]             htrans,
	input  wire logic                   hwrite,
	input  wire logic [2:0]             hsize,
	input  wire logic [31:0]            hwdata,
	input  wire logic                   hready,
	output logic [31:0]                 hrdata,
	output logic                        hreadyout,
	output logic                        hresp,
	// Completion postings
	input  wire logic                   cqe_valid,
	input  wire logic [VW-1:0]          cqe_vector,
	input  wire logic                   cqe_error,
	// Head doorbell writes
	input  wire logic                   db_valid,
	input  wire logic [VW-1:0]          db_vector,
	// Vectors bound to a valid I/O completion queue
	input  wire logic [NUM_VECTORS-1:0] iocq_bound,
	// Interrupt requests, one pulse per vector
	output logic [NUM_VECTORS-1:0]      irq_fire
);

	////////////////////////////////////////////////////////////////////
	// Elaboration check

	if (NUM_VECTORS < 2 || NUM_VECTORS > 65536) begin : g_bad_vectors
		$error("NUM_VECTORS must lie in 2..65536");
	end

	// Vector index width must match the vector count
	if (VW != $clog2(NUM_VECTORS)) begin : g_bad_width
		$error("VW must equal clog2 of NUM_VECTORS");
	end

	////////////////////////////////////////////////////////////////////
	// Declarations

	bus_state_t             state;
	logic [7:0]             addr_q;
	logic                   word_q;
	logic                   accept;
	logic                   wr_en;
	logic [31:0]            rdata_mux;

	logic [7:0]             agg_time;
	logic [7:0]             aggregation_threshold;
	logic [NUM_VECTORS-1:0] vector_coalesce_disable;
	logic [15:0]            vector_select;
	logic                   invalid_field;
	logic                   settings_lost;
	logic [15:0]            prescale;
	intr_mode_t             intr_mode;
	logic                   mode_change;

	logic [15:0]            prescale_cnt;
	logic                   tick;

	logic                   wr_vec_ok;
	logic [VW-1:0]          wr_idx;
	logic                   sel_ok;
	logic [VW-1:0]          sel_idx;

	// A vector may be configured when in range, not admin and bound
	// Bindings passed in so callers re-evaluate when they change
	function automatic logic vec_ok(input logic [15:0] v,
		input logic [NUM_VECTORS-1:0] bound);
		logic [VW-1:0] idx;
		idx = v[VW-1:0];
		vec_ok = (32'(v) < NUM_VECTORS)
			&& (32'(v) != `CIC_ADMIN_VECTOR)
			&& bound[idx];
	endfunction

	////////////////////////////////////////////////////////////////////
	// AHB-Lite bus phases

	// Address phase taken while the bus is ready
	assign accept = hsel && htrans[1] && hready;
	assign wr_en  = (state == BUS_WRITE) && word_q;

	// Writes finish with no wait, reads take one wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state     <= BUS_IDLE;
			addr_q    <= 8'h00;
			word_q    <= 1'b0;
			hreadyout <= 1'b1;
		end else begin
			unique case (state)
				BUS_IDLE, BUS_WRITE, BUS_RDONE: begin
					if (accept) begin
						addr_q    <= haddr[7:0];
						word_q    <= (hsize == `CIC_HSIZE_WORD)
							&& (haddr[31:8] == 24'h000000);
						state     <= hwrite ? BUS_WRITE : BUS_RWAIT;
						hreadyout <= hwrite;
					end else begin
						state     <= BUS_IDLE;
						hreadyout <= 1'b1;
					end
				end
				BUS_RWAIT: begin
					state     <= BUS_RDONE;
					hreadyout <= 1'b1;
				end
			endcase
		end
	end

	// Response is always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
		end
	end

	// Read data mux, unmapped offsets read zero
	always_comb begin
		rdata_mux = 32'h00000000;
		if (word_q) begin
			unique case (addr_q)
				`CIC_OFS_COALESCE: begin
					rdata_mux[`CIC_TIME_HI:`CIC_TIME_LO] = agg_time;
					rdata_mux[`CIC_ENTRIES_HI:`CIC_ENTRIES_LO] =
						aggregation_threshold;
				end
				`CIC_OFS_VECTOR_CFG, `CIC_OFS_VECTOR_QRY: begin
					rdata_mux[`CIC_VSEL_HI:`CIC_VSEL_LO] =
						vector_select;
					rdata_mux[`CIC_DISABLE_BIT] =
						sel_ok && vector_coalesce_disable[sel_idx];
				end
				`CIC_OFS_STATUS: begin
					rdata_mux[`CIC_ST_INVALID] = invalid_field;
					rdata_mux[`CIC_ST_LOST]    = settings_lost;
				end
				`CIC_OFS_PRESCALE: begin
					rdata_mux[15:0] = prescale;
				end
				`CIC_OFS_MODE: begin
					rdata_mux[`CIC_MODE_HI:`CIC_MODE_LO] = intr_mode;
				end
				default: begin
					rdata_mux = 32'h00000000;
				end
			endcase
		end
	end

	// Read data loaded during the wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (state == BUS_RWAIT) begin
			hrdata <= rdata_mux;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Registers

	// Mode write that differs from the current one drops the settings
	assign mode_change = wr_en && (addr_q == `CIC_OFS_MODE)
		&& (hwdata[`CIC_MODE_HI:`CIC_MODE_LO] != intr_mode);

	// Interrupt mode
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			intr_mode <= MODE_PIN;
		end else if (wr_en && addr_q == `CIC_OFS_MODE) begin
			intr_mode <= intr_mode_t'(hwdata[`CIC_MODE_HI:`CIC_MODE_LO]);
		end
	end

	// Global time and threshold settings
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			agg_time              <= `CIC_TIME_RESET;
			aggregation_threshold <= `CIC_ENTRIES_RESET;
		end else if (mode_change) begin
			agg_time              <= `CIC_TIME_RESET;
			aggregation_threshold <= `CIC_ENTRIES_RESET;
		end else if (wr_en && addr_q == `CIC_OFS_COALESCE) begin
			agg_time <= hwdata[`CIC_TIME_HI:`CIC_TIME_LO];
			aggregation_threshold <=
				hwdata[`CIC_ENTRIES_HI:`CIC_ENTRIES_LO];
		end
	end

	// Settings-lost flag, set on mode change, cleared by new settings
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			settings_lost <= 1'b0;
		end else if (mode_change) begin
			settings_lost <= 1'b1;
		end else if (wr_en && addr_q == `CIC_OFS_COALESCE) begin
			settings_lost <= 1'b0;
		end
	end

	// Vector checks for writes and for the held selection
	assign wr_idx    = hwdata[VW-1:0];
	assign wr_vec_ok = vec_ok(hwdata[`CIC_VSEL_HI:`CIC_VSEL_LO],
		iocq_bound);
	assign sel_idx   = vector_select[VW-1:0];
	assign sel_ok    = vec_ok(vector_select, iocq_bound);

	// Selected vector for configuration and query
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			vector_select <= 16'h0000;
		end else if (wr_en && (addr_q == `CIC_OFS_VECTOR_CFG
				|| addr_q == `CIC_OFS_VECTOR_QRY)) begin
			vector_select <= hwdata[`CIC_VSEL_HI:`CIC_VSEL_LO];
		end
	end

	// Per-vector disable flags, written only for a valid vector
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			vector_coalesce_disable <= '0;
		end else if (mode_change) begin
			vector_coalesce_disable <= '0;
		end else if (wr_en && addr_q == `CIC_OFS_VECTOR_CFG
				&& wr_vec_ok) begin
			vector_coalesce_disable[wr_idx] <=
				hwdata[`CIC_DISABLE_BIT];
		end
	end

	// Invalid-field status of the last per-vector command
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			invalid_field <= 1'b0;
		end else if (wr_en && (addr_q == `CIC_OFS_VECTOR_CFG
				|| addr_q == `CIC_OFS_VECTOR_QRY)) begin
			invalid_field <= !wr_vec_ok;
		end
	end

	// Prescaler reload value
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prescale <= 16'(`CIC_PRESCALE_RESET);
		end else if (wr_en && addr_q == `CIC_OFS_PRESCALE) begin
			prescale <= hwdata[15:0];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Time base

	// One-cycle tick every prescale cycles, zero acts as one
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prescale_cnt <= 16'h0000;
			tick         <= 1'b0;
		end else if (prescale_cnt + 16'h0001 >= prescale) begin
			prescale_cnt <= 16'h0000;
			tick         <= 1'b1;
		end else begin
			prescale_cnt <= prescale_cnt + 16'h0001;
			tick         <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Per-vector aggregation, one time limit shared by all vectors

	for (genvar v = 0; v < NUM_VECTORS; v++) begin : g_vec
		logic bypass;

		// Admin vector, disabled vector or zero setting skips holding
		assign bypass = (v == `CIC_ADMIN_VECTOR)
			|| vector_coalesce_disable[v]
			|| agg_time == 8'h00
			|| aggregation_threshold == 8'h00;

		vector_aggregator u_agg (
			.hclk       (hclk),
			.hresetn    (hresetn),
			.tick       (tick),
			.post       (cqe_valid && cqe_vector == VW'(v)),
			.post_error (cqe_error),
			.doorbell   (db_valid && db_vector == VW'(v)),
			.bypass     (bypass),
			.threshold  (aggregation_threshold),
			.time_limit (agg_time),
			.fire       (irq_fire[v])
		);
	end

endmodule

`default_nettype wire

// file: rtl/coalesce_defs.svh
// Purpose: Offsets, field positions, reset values and timing constants
// Assumes: 32-bit AHB-Lite register words, 200 MHz controller clock
// Notes:   Definitions only
`ifndef COALESCE_DEFS_SVH
`define COALESCE_DEFS_SVH

// Register byte offsets
`define CIC_OFS_COALESCE   8'h00
`define CIC_OFS_VECTOR_CFG 8'h04
`define CIC_OFS_VECTOR_QRY 8'h08
`define CIC_OFS_STATUS     8'h0C
`define CIC_OFS_PRESCALE   8'h10
`define CIC_OFS_MODE       8'h14

// Coalescing settings word fields
`define CIC_TIME_HI 15
`define CIC_TIME_LO 8
`define CIC_ENTRIES_HI 7
`define CIC_ENTRIES_LO 0

// Per-vector configuration word fields
`define CIC_DISABLE_BIT 16
`define CIC_VSEL_HI     15
`define CIC_VSEL_LO     0

// Status bits
`define CIC_ST_INVALID 0
`define CIC_ST_LOST    1

// Mode register field
`define CIC_MODE_HI 1
`define CIC_MODE_LO 0

// Reset values
`define CIC_TIME_RESET 8'h00
`define CIC_ENTRIES_RESET 8'h00

// Time base: aggregation step in microseconds, clock rate in MHz
`define CIC_TICK_US   100
`define CIC_CLK_MHZ   200
`define CIC_PRESCALE_RESET (`CIC_TICK_US * `CIC_CLK_MHZ)

// Vector that serves the administrative completion queue
`define CIC_ADMIN_VECTOR 0

// Word transfer size code
`define CIC_HSIZE_WORD 3'h2

`endif

// file: rtl/coalesce_pkg.sv
// Purpose: Types shared by the coalescer files
// Assumes: Nothing beyond the defines header
// Notes:   Bus phase states are one-hot
package coalesce_pkg;

	// Bus data phase tracking
	typedef enum logic [3:0] {
		BUS_IDLE  = 4'h1,
		BUS_WRITE = 4'h2,
		BUS_RWAIT = 4'h4,
		BUS_RDONE = 4'h8
	} bus_state_t;

	// Interrupt signalling modes
	typedef enum logic [1:0] {
		MODE_PIN   = 2'h0,
		MODE_MSI   = 2'h1,
		MODE_MMSI  = 2'h2,
		MODE_MSIX  = 2'h3
	} intr_mode_t;

endpackage

// file: rtl/vector_aggregator.sv
// Purpose: Entry count and hold-off timer for one interrupt vector
// Assumes: tick is a one-cycle pulse every aggregation step
// Notes:   Fire is a registered one-cycle pulse
`timescale 1ns/1ps
`default_nettype none

module vector_aggregator
	import coalesce_pkg::*;
(
	// Clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// Time base and events
	input  wire logic       tick,
	input  wire logic       post,
	input  wire logic       post_error,
	input  wire logic       doorbell,
	// Settings
	input  wire logic       bypass,
	input  wire logic [7:0] threshold,
	input  wire logic [7:0] time_limit,
	// Interrupt request
	output logic            fire
);

	logic       pending;
	logic [8:0] count;
	logic [7:0] timer;
	logic       next_pending;
	logic [8:0] next_count;
	logic [7:0] next_timer;
	logic       due;

	// Doorbell restarts count and timer, a new post still counts
	always_comb begin
		next_count = doorbell ? 9'h000 : count;
		next_timer = doorbell ? 8'h00 : timer;
		if (post && next_count != 9'h1FF) begin
			next_count = next_count + 9'h001;
		end
		if (tick && pending && next_timer != 8'hFF) begin
			next_timer = next_timer + 8'h01;
		end
		next_pending = pending | post;
		// Whichever of count or time is met first
		due = next_pending && (bypass
			|| (post && post_error)
			|| next_count >= ({1'b0, threshold} + 9'h001)
			|| next_timer >= time_limit);
	end

	// Signalling clears the accumulated state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pending <= 1'b0;
			count   <= 9'h000;
			timer   <= 8'h00;
			fire    <= 1'b0;
		end else if (due) begin
			pending <= 1'b0;
			count   <= 9'h000;
			timer   <= 8'h00;
			fire    <= 1'b1;
		end else begin
			pending <= next_pending;
			count   <= next_count;
			timer   <= next_timer;
			fire    <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// file: dv/coalesce_checker.sv
// Purpose: Port-level assertions for the completion coalescer
// Assumes: One clock domain, async active-low reset
// Notes:   Shadows the settings word from observed bus writes
`timescale 1ns/1ps
`default_nettype none
`include "coalesce_defs.svh"

module coalesce_checker #(
	parameter int NUM_VECTORS = 8,
	parameter int VW          = 3
)(
	// Clock and reset
	input wire logic                   hclk,
	input wire logic                   hresetn,
	// Bus
	input wire logic                   hsel,
	input wire logic [31:0]            haddr,
	input wire logic [1:0]             htrans,
	input wire logic                   hwrite,
	input wire logic [31:0]            hwdata,
	input wire logic                   hready,
	input wire logic                   hreadyout,
	input wire logic                   hresp,
	// Events and interrupts
	input wire logic                   cqe_valid,
	input wire logic [VW-1:0]          cqe_vector,
	input wire logic                   cqe_error,
	input wire logic [NUM_VECTORS-1:0] irq_fire
);
	logic       wr_phase;
	logic [7:0] coal_time;
	logic [7:0] coal_entries;

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	////////////////////////////////////////////////////////////////////////
	// Settings word shadow, loaded in the write data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_phase  <= 1'b0;
			coal_time <= 8'h00;
			coal_entries <= 8'h00;
		end else if (hready) begin
			wr_phase <= hsel && htrans[1] && hwrite &&
				haddr == {24'h0, `CIC_OFS_COALESCE};
			if (wr_phase) begin
				coal_time    <= hwdata[`CIC_TIME_HI:`CIC_TIME_LO];
				coal_entries <= hwdata[`CIC_ENTRIES_HI:`CIC_ENTRIES_LO];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	AST_RD_WAIT: assert property (hsel && htrans[1] && hready && !hwrite
		|=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
	AST_WR_NOWAIT: assert property (hsel && htrans[1] && hready && hwrite
		|=> hreadyout) else $error("write stalled");
	AST_WAIT_ONE: assert property (!hreadyout |=> hreadyout)
		else $error("wait state too long");
	AST_OKAY: assert property (hsel && htrans[1] && hready
		|-> ##[1:2] !hresp) else $error("response not okay");
	AST_ADMIN: assert property (cqe_valid && cqe_vector == 0
		|=> irq_fire[0]) else $error("admin vector held back");
	AST_ERROR: assert property (cqe_valid && cqe_error
		|=> irq_fire[$past(cqe_vector)]) else $error("error entry held");
	AST_BYPASS: assert property (cqe_valid &&
		(coal_time == 8'h00 || coal_entries == 8'h00)
		|=> irq_fire[$past(cqe_vector)]) else $error("zero setting held");
	AST_QUIET: assert property ($rose(hresetn) |-> irq_fire == '0)
		else $error("interrupt right after reset");
endmodule
`default_nettype wire

// file: dv/host_model.sv
// Purpose: Host side: bus master for settings, queue bindings
// Assumes: Called just after a rising edge of hclk
// Notes:   Waits on hready with no fixed latency
`timescale 1ns/1ps
`default_nettype none
`include "coalesce_defs.svh"

module host_model (
	// Clock and bus return
	input  wire logic        hclk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	// Bus request
	output logic             hsel,
	output logic [31:0]      haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata,
	// Vectors bound to I/O completion queues
	output logic [7:0]       iocq_bound
);
	// Idle bus; vectors 1 to 5 bound before any vector setup
	initial begin
		hsel       = 1'b0;
		haddr      = 32'h0;
		htrans     = 2'h0;
		hwrite     = 1'b0;
		hsize      = `CIC_HSIZE_WORD;
		hwdata     = 32'h0;
		iocq_bound = 8'h3E;
	end

	// Single word transfer, each phase held until hready
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= w ? d : ~hwdata;
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
	endtask
endmodule
`default_nettype wire

// file: dv/tb_top.sv
// Purpose: Self-checking bench for the completion coalescer
// Assumes: Prescale shortened to 4 cycles per time step
// Notes:   Vector 3 entries left pending fire later by timer
`timescale 1ns/1ps
`default_nettype none
`include "coalesce_defs.svh"

bind completion_interrupt_coalescer coalesce_checker #(
	.NUM_VECTORS(NUM_VECTORS), .VW(VW)) chk (.hclk(hclk),
	.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .cqe_valid(cqe_valid),
	.cqe_vector(cqe_vector), .cqe_error(cqe_error), .irq_fire(irq_fire));

module tb_top;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize, cqe_vector, db_vector;
	logic        cqe_valid, cqe_error, db_valid;
	logic [7:0]  iocq_bound, irq_fire;
	int          errors, checks, cycles;

	completion_interrupt_coalescer uut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.cqe_valid(cqe_valid), .cqe_vector(cqe_vector),
		.cqe_error(cqe_error), .db_valid(db_valid), .db_vector(db_vector),
		.iocq_bound(iocq_bound), .irq_fire(irq_fire));
	host_model host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .iocq_bound(iocq_bound));

	////////////////////////////////////////////////////////////////////////
	// Shared tasks
	task automatic close_out;
		$display("errors=%0d checks=%0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		@(posedge hclk);
		host.xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		@(posedge hclk);
		host.xfer(1'b0, a, 32'h0, q);
		cmp(q, exp);
	endtask
	// One entry posted; fire checked in the following cycle
	task automatic post(input logic [2:0] v, input logic err,
		input logic exp);
		@(posedge hclk);
		cqe_valid  <= 1'b1;
		cqe_vector <= v;
		cqe_error  <= err;
		@(posedge hclk);
		cqe_valid <= 1'b0;
		cqe_error <= 1'b0;
		#1 cmp({31'h0, irq_fire[v]}, {31'h0, exp});
	endtask

	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset;
		rd(`CIC_OFS_COALESCE, 32'h0);
		rd(`CIC_OFS_PRESCALE, 32'h4E20);
		rd(`CIC_OFS_VECTOR_CFG, 32'h0);
		wr(8'h40, 32'hFFFFFFFF);
		rd(8'h40, 32'h0);
		wr(`CIC_OFS_PRESCALE, 32'h4);
		repeat (20010) @(posedge hclk);
		rd(`CIC_OFS_PRESCALE, 32'h4);
	endtask
	task automatic t_bypass;
		post(3'h3, 1'b0, 1'b1);
		wr(`CIC_OFS_COALESCE, 32'h1000);
		post(3'h3, 1'b0, 1'b1);
		wr(`CIC_OFS_COALESCE, 32'hFF02);
		post(3'h0, 1'b0, 1'b1);
		post(3'h1, 1'b1, 1'b1);
	endtask
	task automatic t_thresh;
		post(3'h3, 1'b0, 1'b0);
		post(3'h3, 1'b0, 1'b0);
		post(3'h3, 1'b0, 1'b1);
		post(3'h3, 1'b0, 1'b0);
		rd(`CIC_OFS_COALESCE, 32'hFF02);
	endtask
	task automatic t_doorbell;
		wr(`CIC_OFS_COALESCE, 32'hFF01);
		post(3'h2, 1'b0, 1'b0);
		@(posedge hclk);
		db_valid  <= 1'b1;
		db_vector <= 3'h2;
		@(posedge hclk);
		db_valid <= 1'b0;
		post(3'h2, 1'b0, 1'b0);
		post(3'h2, 1'b0, 1'b1);
	endtask
	task automatic t_timer;
		int k;
		wr(`CIC_OFS_COALESCE, 32'h02FF);
		post(3'h5, 1'b0, 1'b0);
		k = 0;
		do begin
			@(posedge hclk);
			#1 k++;
		end while (irq_fire[5] !== 1'b1 && k < 20);
		cmp(32'(k >= 5 && k <= 9), 32'h1);
	endtask
	task automatic t_vector;
		logic [31:0] bad [3];
		bad = '{32'h10000, 32'h10006, 32'h10009};
		wr(`CIC_OFS_COALESCE, 32'hFF02);
		wr(`CIC_OFS_VECTOR_CFG, 32'h10004);
		rd(`CIC_OFS_STATUS, 32'h0);
		rd(`CIC_OFS_VECTOR_CFG, 32'h10004);
		post(3'h4, 1'b0, 1'b1);
		wr(`CIC_OFS_VECTOR_QRY, 32'h2);
		rd(`CIC_OFS_VECTOR_CFG, 32'h2);
		foreach (bad[i]) begin
			wr(`CIC_OFS_VECTOR_CFG, bad[i]);
			rd(`CIC_OFS_STATUS, 32'h1);
		end
		wr(`CIC_OFS_VECTOR_CFG, 32'h4);
		post(3'h4, 1'b0, 1'b0);
	endtask
	task automatic t_mode;
		for (int m = 1; m <= 4; m++) begin
			wr(`CIC_OFS_COALESCE, 32'hFF02);
			wr(`CIC_OFS_MODE, 32'(m % 4));
			rd(`CIC_OFS_COALESCE, 32'h0);
			rd(`CIC_OFS_STATUS, 32'h2);
			rd(`CIC_OFS_MODE, 32'(m % 4));
		end
		wr(`CIC_OFS_COALESCE, 32'hFF02);
		rd(`CIC_OFS_STATUS, 32'h0);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Clock, hang guard and main sequence
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 30000) begin
			errors++;
			close_out();
		end
	end
	initial begin
		hresetn    = 1'b0;
		cqe_valid  = 1'b0;
		cqe_vector = 3'h0;
		cqe_error  = 1'b0;
		db_valid   = 1'b0;
		db_vector  = 3'h0;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_bypass();
		t_thresh();
		t_doorbell();
		t_timer();
		t_vector();
		t_mode();
		close_out();
	end
endmodule
`default_nettype wire
